/* File: hw/sp_serial_port.sv */
// serial port with shift mode, 10-bit async mode and timer 2 baud source
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - either timer 2 baud select enters baud mode; tx and rx rates independent
// - port 1 selects sit in timer 2 control; port 2 selects in power control
// - baud mode: high byte overflow reloads both bytes from reload pair
// - with timer 2 source, bit rate is overflow rate over 16
// - internal baud timing advances every state time, fosc/(32*(65536-reload))
// - baud mode overflow sets no overflow flag and raises no interrupt
// - baud mode: external falling edge sets edge flag, never reloads
// - shift mode moves 8 bits lsb first on data pin, clock at fosc/12
// - shift mode buffer write loads marker one; send starts a cycle later
// - shift clock low S3-S5, high S6-S2; shift right at S6P2
// - zero fill; marker beside msb gives last shift, then send off and done
// - shift mode rx starts on enable with done clear; loads 111111110 at S6P2
// - shift mode rx shifts left per cycle, inserting pin sampled at S5P2
// - initial zero at left: final shift, load buffer, end and set done at S1P1
// - async frame: zero start, 8 data lsb first, one stop kept as ninth bit
// - async write loads marker; send starts after next divide-by-16 rollover
// - start bit first, data a bit later, shifts after; done at 10th rollover
// - async rx watches pin at 16x; falling edge clears divider, loads 1ff
// - majority of samples at states 7,8,9; bad start returns to search
// - 9-bit rx register; start bit at left gives load without a final shift
// - load only if done clear and stop good or check off; always re-search
module sp_serial_port (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // serial pins
  input  wire logic       i_rxd,
  output logic            o_rxd_out,
  output logic            o_rxd_oe,
  output logic            o_txd,
  // timer pins and timer 1 overflow
  input  wire logic       i_t2_count_pin,
  input  wire logic       i_t2_ext_pin,
  input  wire logic       i_timer1_ovf,
  // second port baud selects
  output logic            o_port2_tx_baud_select,
  output logic            o_port2_rx_baud_select
);

  // ==========================================================
  // registers
  logic [7:0]       serial_control_reg_q;
  logic [7:0]       serial_control_reg_d;
  logic [7:0]       serial_buffer_q;
  logic [7:0]       timer2_control_reg_q;
  logic [7:0]       timer2_control_reg_d;
  logic [7:0]       power_control_reg_q;
  logic [15:0]      timer2_q;
  logic [15:0]      timer2_d;
  logic [7:0]       reload_low_byte_q;
  logic [7:0]       reload_high_byte_q;
  logic [7:0]       rdata_q;
  logic [3:0]       ph_q;
  logic [2:0]       rxd_sy_q;
  logic [2:0]       cnt_sy_q;
  logic [2:0]       ext_sy_q;
  logic             rxd_prev_q;
  sp_pkg::sp_seq_t  tx_st_q;
  sp_pkg::sp_seq_t  rx_st_q;
  logic [8:0]       tx_sh_q;
  logic [8:0]       rx_sh_q;
  logic             data_en_q;
  logic [3:0]       tx_div_q;
  logic [3:0]       rx_div_q;
  logic             smp_a_q;
  logic             smp_b_q;
  logic             m0_bit_q;
  logic             txd_q;
  logic             rxd_out_q;
  logic             rxd_oe_q;
  logic             p2_tx_q;
  logic             p2_rx_q;

  // ==========================================================
  // decode
  wire wr_serial_control_reg  = i_wr & (i_addr == sp_pkg::ADDR_SERIAL_CONTROL_REG);
  wire wr_serial_buffer  = i_wr & (i_addr == sp_pkg::ADDR_SERIAL_BUFFER);
  wire wr_timer2_control_reg = i_wr & (i_addr == sp_pkg::ADDR_TIMER2_CONTROL_REG);
  wire wr_t2lo  = i_wr & (i_addr == sp_pkg::ADDR_T2LO);
  wire wr_t2hi  = i_wr & (i_addr == sp_pkg::ADDR_T2HI);
  wire wr_rllo  = i_wr & (i_addr == sp_pkg::ADDR_RLLO);
  wire wr_rlhi  = i_wr & (i_addr == sp_pkg::ADDR_RLHI);
  wire wr_power_control_reg  = i_wr & (i_addr == sp_pkg::ADDR_POWER_CONTROL_REG);

  wire mode0    = ~serial_control_reg_q[sp_pkg::SC_SM0]
                & ~serial_control_reg_q[sp_pkg::SC_SM1];
  wire mpc      = serial_control_reg_q[sp_pkg::SC_MPC];
  wire ren      = serial_control_reg_q[sp_pkg::SC_REN];
  wire ri       = serial_control_reg_q[sp_pkg::SC_RI];

  // ==========================================================
  // phase timing
  wire ph_s1p1  = (ph_q == sp_pkg::PH_S1P1);
  wire ph_s5p2  = (ph_q == sp_pkg::PH_S5P2);
  wire ph_s6p2  = (ph_q == sp_pkg::PH_S6P2);
  wire state_end = ph_q[0];
  // shift clock low from S3P1 through S5P2
  wire sclk_low = (ph_q >= sp_pkg::PH_S3P1) & (ph_q <= sp_pkg::PH_S5P2);

  // ==========================================================
  // synchronised pins; stage 0 is read only by stage 1
  wire rxd      = rxd_sy_q[1];
  wire cnt_fall = cnt_sy_q[2] & ~cnt_sy_q[1];
  wire ext_fall = ext_sy_q[2] & ~ext_sy_q[1];

  // ==========================================================
  // timer 2
  wire tx_baud_from_timer2      = timer2_control_reg_q[sp_pkg::T2_TX_BAUD_FROM_TIMER2];
  wire rclk      = timer2_control_reg_q[sp_pkg::T2_RCLK];
  wire baud_mode = tx_baud_from_timer2 | rclk;
  wire t2_run    = timer2_control_reg_q[sp_pkg::T2_RUN];
  wire t2_cts    = timer2_control_reg_q[sp_pkg::T2_CTS];
  wire exen      = timer2_control_reg_q[sp_pkg::T2_EXEN];
  wire cprl      = timer2_control_reg_q[sp_pkg::T2_CPRL];
  // baud timing steps each state time, plain timing each machine cycle
  wire t2_step   = baud_mode ? state_end : ph_s6p2;
  wire t2_inc    = t2_run & (t2_cts ? cnt_fall : t2_step);
  wire t2_ovf    = t2_inc & (timer2_q == sp_pkg::T2_TOP);
  // external edge reloads only outside baud mode
  wire ext_rld   = ext_fall & exen & ~baud_mode & ~cprl;
  wire [15:0] reload_val = {reload_high_byte_q, reload_low_byte_q};
  wire tf2_set   = t2_ovf & ~baud_mode;
  wire external_edge_flag_set  = ext_fall & exen;

  always_comb begin
    timer2_d = timer2_q;
    if (t2_ovf | ext_rld) begin
      timer2_d = reload_val;
    end else if (t2_inc) begin
      timer2_d = timer2_q + 16'h0001;
    end
    // software access wins; it is only safe with the timer stopped
    if (wr_t2lo) begin
      timer2_d[7:0] = i_wdata;
    end
    if (wr_t2hi) begin
      timer2_d[15:8] = i_wdata;
    end
  end

  always_comb begin
    timer2_control_reg_d = wr_timer2_control_reg ? i_wdata : timer2_control_reg_q;
    // a flag event in a clearing cycle is kept
    timer2_control_reg_d[sp_pkg::T2_TF] =
      timer2_control_reg_d[sp_pkg::T2_TF] | tf2_set;
    timer2_control_reg_d[sp_pkg::T2_EXF] =
      timer2_control_reg_d[sp_pkg::T2_EXF] | external_edge_flag_set;
  end

  // ==========================================================
  // baud ticks at 16x, chosen per direction
  wire tx_tick = tx_baud_from_timer2 ? t2_ovf : i_timer1_ovf;
  wire rx_tick = rclk ? t2_ovf : i_timer1_ovf;
  wire tx_roll = tx_tick & (tx_div_q == sp_pkg::DIV_TOP);

  // ==========================================================
  // transmit
  wire tx_last  = (tx_sh_q[8:1] == sp_pkg::TX_LAST_PAT);
  wire [8:0] tx_shr = {1'b0, tx_sh_q[8:1]};
  wire tx_send  = (tx_st_q == sp_pkg::SP_RUN) | (tx_st_q == sp_pkg::SP_LAST);
  logic ti_set;
  logic m1_ti;

  always_comb begin
    ti_set = 1'b0;
    m1_ti = 1'b0;
    if (mode0) begin
      ti_set = (tx_st_q == sp_pkg::SP_LAST) & ph_s1p1;
    end else begin
      m1_ti = (tx_st_q == sp_pkg::SP_RUN) & tx_roll & data_en_q & tx_last;
      ti_set = m1_ti;
    end
  end

  // ==========================================================
  // receive
  wire maj = (smp_a_q & smp_b_q) | (smp_a_q & rxd) | (smp_b_q & rxd);
  wire rx_busy1  = ~mode0 & (rx_st_q == sp_pkg::SP_RUN);
  wire rx_decide = rx_busy1 & rx_tick & (rx_div_q == sp_pkg::SMP_C);
  wire rx_first  = (rx_sh_q == sp_pkg::M1_RX_INIT);
  wire rx_bad    = rx_decide & rx_first & maj;
  wire rx_final  = rx_decide & ~rx_sh_q[8];
  wire rx_accept = rx_final & ~ri & (~mpc | maj);
  wire m1_edge   = ~mode0 & ren & (rx_st_q == sp_pkg::SP_IDLE)
                 & rx_tick & rxd_prev_q & ~rxd;
  wire m0_load   = mode0 & (rx_st_q == sp_pkg::SP_LAST) & ph_s1p1;
  wire ri_set    = rx_accept | m0_load;
  // first bit in lands highest, so reverse into the buffer
  wire [7:0] rx_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign rx_rev[gi] = rx_sh_q[7 - gi];
    end
  endgenerate

  always_comb begin
    serial_control_reg_d = wr_serial_control_reg ? i_wdata : serial_control_reg_q;
    serial_control_reg_d[sp_pkg::SC_TI] =
      serial_control_reg_d[sp_pkg::SC_TI] | ti_set;
    serial_control_reg_d[sp_pkg::SC_RI] =
      serial_control_reg_d[sp_pkg::SC_RI] | ri_set;
    if (rx_accept) begin
      serial_control_reg_d[sp_pkg::SC_RB8] = maj;
    end
  end

  // ==========================================================
  // pin drive
  logic txd_d;
  always_comb begin
    if (mode0) begin
      txd_d = ((tx_send | (rx_st_q == sp_pkg::SP_RUN)
              | (rx_st_q == sp_pkg::SP_LAST)) & sclk_low) ? 1'b0 : 1'b1;
    end else if (tx_st_q == sp_pkg::SP_RUN) begin
      txd_d = data_en_q ? tx_sh_q[0] : 1'b0;
    end else begin
      txd_d = 1'b1;
    end
  end

  // ==========================================================
  // read mux; data shows in the cycle after the strobe only
  logic [7:0] rd_sel;
  always_comb begin
    unique case (i_addr)
      sp_pkg::ADDR_SERIAL_CONTROL_REG:  rd_sel = serial_control_reg_q;
      sp_pkg::ADDR_SERIAL_BUFFER:  rd_sel = serial_buffer_q;
      sp_pkg::ADDR_TIMER2_CONTROL_REG: rd_sel = timer2_control_reg_q;
      sp_pkg::ADDR_T2LO:  rd_sel = timer2_q[7:0];
      sp_pkg::ADDR_T2HI:  rd_sel = timer2_q[15:8];
      sp_pkg::ADDR_RLLO:  rd_sel = reload_low_byte_q;
      sp_pkg::ADDR_RLHI:  rd_sel = reload_high_byte_q;
      sp_pkg::ADDR_POWER_CONTROL_REG:  rd_sel = power_control_reg_q;
    endcase
  end

  // ==========================================================
  // software registers and timer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      serial_control_reg_q <= sp_pkg::RST_BYTE;
      timer2_control_reg_q <= sp_pkg::RST_BYTE;
      power_control_reg_q  <= sp_pkg::RST_BYTE;
      reload_low_byte_q    <= sp_pkg::RST_BYTE;
      reload_high_byte_q   <= sp_pkg::RST_BYTE;
      timer2_q             <= sp_pkg::RST_WORD;
      rdata_q              <= sp_pkg::RST_BYTE;
    end else begin
      serial_control_reg_q <= serial_control_reg_d;
      timer2_control_reg_q <= timer2_control_reg_d;
      timer2_q             <= timer2_d;
      rdata_q              <= i_rd ? rd_sel : sp_pkg::RST_BYTE;
      if (wr_power_control_reg) begin
        power_control_reg_q <= i_wdata;
      end
      if (wr_rllo) begin
        reload_low_byte_q <= i_wdata;
      end
      if (wr_rlhi) begin
        reload_high_byte_q <= i_wdata;
      end
    end
  end

  // ==========================================================
  // phase counter and synchronisers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ph_q     <= sp_pkg::RST_NIB;
      rxd_sy_q <= 3'h7;
      cnt_sy_q <= 3'h7;
      ext_sy_q <= 3'h7;
    end else begin
      ph_q     <= ph_s6p2 ? sp_pkg::PH_S1P1 : ph_q + 4'h1;
      rxd_sy_q <= {rxd_sy_q[1:0], i_rxd};
      cnt_sy_q <= {cnt_sy_q[1:0], i_t2_count_pin};
      ext_sy_q <= {ext_sy_q[1:0], i_t2_ext_pin};
    end
  end

  // ==========================================================
  // transmit sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tx_st_q   <= sp_pkg::SP_IDLE;
      tx_sh_q   <= sp_pkg::RST_SH;
      data_en_q <= 1'b0;
      tx_div_q  <= sp_pkg::RST_NIB;
    end else begin
      if (tx_tick) begin
        tx_div_q <= tx_div_q + 4'h1;
      end
      if (wr_serial_buffer) begin
        tx_sh_q   <= {1'b1, i_wdata};
        tx_st_q   <= sp_pkg::SP_ARM;
        data_en_q <= 1'b0;
      end else if (mode0) begin
        unique case (tx_st_q)
          sp_pkg::SP_IDLE: ;
          sp_pkg::SP_ARM: begin
            if (ph_s6p2) begin
              tx_st_q <= sp_pkg::SP_RUN;
            end
          end
          sp_pkg::SP_RUN: begin
            if (ph_s6p2) begin
              tx_sh_q <= tx_shr;
              if (tx_last) begin
                tx_st_q <= sp_pkg::SP_LAST;
              end
            end
          end
          sp_pkg::SP_LAST: begin
            if (ph_s1p1) begin
              tx_st_q <= sp_pkg::SP_IDLE;
            end
          end
        endcase
      end else if (tx_roll) begin
        unique case (tx_st_q)
          sp_pkg::SP_IDLE: ;
          sp_pkg::SP_ARM: tx_st_q <= sp_pkg::SP_RUN;
          sp_pkg::SP_RUN: begin
            if (!data_en_q) begin
              data_en_q <= 1'b1;
            end else begin
              tx_sh_q <= tx_shr;
              if (m1_ti) begin
                tx_st_q   <= sp_pkg::SP_IDLE;
                data_en_q <= 1'b0;
              end
            end
          end
          sp_pkg::SP_LAST: tx_st_q <= sp_pkg::SP_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // receive sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rx_st_q    <= sp_pkg::SP_IDLE;
      rx_sh_q    <= sp_pkg::RST_SH;
      rx_div_q   <= sp_pkg::RST_NIB;
      rxd_prev_q <= 1'b1;
      smp_a_q    <= 1'b1;
      smp_b_q    <= 1'b1;
      m0_bit_q   <= 1'b1;
    end else if (mode0) begin
      rxd_prev_q <= 1'b1;
      unique case (rx_st_q)
        sp_pkg::SP_IDLE: begin
          if (ren & ~ri) begin
            rx_st_q <= sp_pkg::SP_ARM;
          end
        end
        sp_pkg::SP_ARM: begin
          if (ph_s6p2) begin
            rx_sh_q <= sp_pkg::M0_RX_INIT;
            rx_st_q <= sp_pkg::SP_RUN;
          end
        end
        sp_pkg::SP_RUN: begin
          if (ph_s5p2) begin
            m0_bit_q <= rxd;
          end
          if (ph_s6p2) begin
            rx_sh_q <= {rx_sh_q[7:0], m0_bit_q};
            if (!rx_sh_q[7]) begin
              rx_st_q <= sp_pkg::SP_LAST;
            end
          end
        end
        sp_pkg::SP_LAST: begin
          if (ph_s1p1) begin
            rx_st_q <= sp_pkg::SP_IDLE;
          end
        end
      endcase
    end else if (rx_tick) begin
      rxd_prev_q <= rxd;
      if (m1_edge) begin
        rx_div_q <= sp_pkg::RST_NIB;
        rx_sh_q  <= sp_pkg::M1_RX_INIT;
        rx_st_q  <= sp_pkg::SP_RUN;
      end else if (rx_busy1) begin
        rx_div_q <= rx_div_q + 4'h1;
        if (rx_div_q == sp_pkg::SMP_A) begin
          smp_a_q <= rxd;
        end
        if (rx_div_q == sp_pkg::SMP_B) begin
          smp_b_q <= rxd;
        end
        if (rx_bad | rx_final) begin
          rx_st_q <= sp_pkg::SP_IDLE;
        end else if (rx_decide) begin
          rx_sh_q <= {rx_sh_q[7:0], maj};
        end
      end else if (rx_st_q != sp_pkg::SP_IDLE) begin
        rx_st_q <= sp_pkg::SP_IDLE;
      end
    end
  end

  // ==========================================================
  // receive buffer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      serial_buffer_q <= sp_pkg::RST_BYTE;
    end else if (m0_load | rx_accept) begin
      serial_buffer_q <= rx_rev;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      txd_q     <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q  <= 1'b0;
      p2_tx_q   <= 1'b0;
      p2_rx_q   <= 1'b0;
    end else begin
      txd_q     <= txd_d;
      rxd_out_q <= tx_sh_q[0];
      rxd_oe_q  <= mode0 & tx_send;
      p2_tx_q   <= power_control_reg_q[sp_pkg::PC_TX2];
      p2_rx_q   <= power_control_reg_q[sp_pkg::PC_RX2];
    end
  end

  assign o_rdata   = rdata_q;
  assign o_txd     = txd_q;
  assign o_rxd_out = rxd_out_q;
  assign o_rxd_oe  = rxd_oe_q;
  assign o_port2_tx_baud_select = p2_tx_q;
  assign o_port2_rx_baud_select = p2_rx_q;

endmodule

`default_nettype wire

/* File: inc/sp_pkg.sv */
// serial port package: register map, field positions, reset values, states
package sp_pkg;

  // ==========================================================
  // register indices on the plain register port
  localparam logic [2:0] ADDR_SERIAL_CONTROL_REG  = 3'h0;
  localparam logic [2:0] ADDR_SERIAL_BUFFER  = 3'h1;
  localparam logic [2:0] ADDR_TIMER2_CONTROL_REG = 3'h2;
  localparam logic [2:0] ADDR_T2LO  = 3'h3;
  localparam logic [2:0] ADDR_T2HI  = 3'h4;
  localparam logic [2:0] ADDR_RLLO  = 3'h5;
  localparam logic [2:0] ADDR_RLHI  = 3'h6;
  localparam logic [2:0] ADDR_POWER_CONTROL_REG  = 3'h7;

  // ==========================================================
  // serial_control_reg fields
  localparam int SC_SM0 = 7;
  localparam int SC_SM1 = 6;
  localparam int SC_MPC = 5;
  localparam int SC_REN = 4;
  localparam int SC_RB8 = 2;
  localparam int SC_TI  = 1;
  localparam int SC_RI  = 0;

  // ==========================================================
  // timer2_control_reg and power_control_reg fields
  localparam int T2_TF   = 7;
  localparam int T2_EXF  = 6;
  localparam int T2_RCLK = 5;
  localparam int T2_TX_BAUD_FROM_TIMER2 = 4;
  localparam int T2_EXEN = 3;
  localparam int T2_RUN  = 2;
  localparam int T2_CTS  = 1;
  localparam int T2_CPRL = 0;
  localparam int PC_TX2  = 4;
  localparam int PC_RX2  = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [8:0]  RST_SH   = 9'h000;
  localparam logic [3:0]  RST_NIB  = 4'h0;

  // ==========================================================
  // machine cycle: 12 oscillator clocks, two phases per state
  localparam logic [3:0]  PH_S1P1 = 4'h0;
  localparam logic [3:0]  PH_S3P1 = 4'h4;
  localparam logic [3:0]  PH_S5P2 = 4'h9;
  localparam logic [3:0]  PH_S6P2 = 4'hb;

  // ==========================================================
  // shift patterns, divider and sample points
  localparam logic [8:0]  M0_RX_INIT  = 9'h1fe;
  localparam logic [8:0]  M1_RX_INIT  = 9'h1ff;
  localparam logic [7:0]  TX_LAST_PAT = 8'h01;
  localparam logic [3:0]  DIV_TOP     = 4'hf;
  localparam logic [3:0]  SMP_A       = 4'h6;
  localparam logic [3:0]  SMP_B       = 4'h7;
  localparam logic [3:0]  SMP_C       = 4'h8;
  localparam logic [15:0] T2_TOP      = 16'hffff;

  // ==========================================================
  // sequencer states, gray along idle-arm-run-last
  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_ARM  = 2'b01,
    SP_RUN  = 2'b11,
    SP_LAST = 2'b10
  } sp_seq_t;

endpackage

/* File: bench/sp_peer.sv */
// remote serial device: async frames and shift-mode data source
`timescale 1ns/1ps
`default_nettype none
module sp_peer (
  input  wire logic i_sys_clk,
  input  wire logic i_sclk,
  output logic      o_rxd
);
  logic [7:0] sh_byte;
  logic       sh_en;
  logic [2:0] sh_idx;
  initial begin
    o_rxd = 1'b1;
    sh_en = 1'b0;
    sh_idx = 3'h0;
    sh_byte = 8'h00;
  end
  // ==========================================================
  // async frame; line is left at mark after the stop bit
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    sh_en <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      o_rxd <= f[k];
      repeat (bt) @(posedge i_sys_clk);
    end
  endtask
  // short low pulse, too brief to survive the majority vote
  task automatic glitch(input int n);
    o_rxd <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_rxd <= 1'b1;
  endtask
  task automatic arm(input logic [7:0] b);
    sh_byte = b;
    sh_idx = 3'h0;
    sh_en = 1'b1;
  endtask
  // ==========================================================
  // shift mode: next bit presented on each falling shift clock
  always @(negedge i_sclk) begin
    if (sh_en) begin
      o_rxd <= sh_byte[sh_idx];
      sh_idx <= sh_idx + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/sp_serial_port_sva.sv */
// checker: port-level properties of the serial port
`timescale 1ns/1ps
`default_nettype none
module sp_serial_port_sva (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rxd_out,
  input wire logic       o_rxd_oe,
  input wire logic       o_txd,
  input wire logic       o_port2_tx_baud_select,
  input wire logic       o_port2_rx_baud_select
);
  // ==========================================================
  // helper state
  logic       mode0_q;
  logic [3:0] cnt_q;
  wire logic  pc_wr = i_wr && (i_addr == sp_pkg::ADDR_POWER_CONTROL_REG);
  wire logic  sc_wr = i_wr && (i_addr == sp_pkg::ADDR_SERIAL_CONTROL_REG);
  wire logic  m0_wr = sc_wr && !i_wdata[sp_pkg::SC_SM0] && !i_wdata[sp_pkg::SC_SM1];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode0_q <= 1'b1;
      cnt_q <= 4'h0;
    end else begin
      if (sc_wr) begin
        mode0_q <= m0_wr;
      end
      // pulses count only while the data pin is driven
      if (!o_rxd_oe) begin
        cnt_q <= 4'h0;
      end else if ($fell(o_txd)) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_clk_low;
    (!o_txd) [*6] ##1 o_txd;
  endsequence
  // the select pins trail a power control write by two edges
  chk_p2_tx_sel: assert property (pc_wr |-> ##2
    o_port2_tx_baud_select == $past(i_wdata[sp_pkg::PC_TX2], 2))
    else $error("port2 tx select wrong");
  chk_p2_rx_hold: assert property (!pc_wr |-> ##2 $stable(o_port2_rx_baud_select))
    else $error("port2 rx select moved");
  chk_power_control_reg_read: assert property (i_rd && i_addr == sp_pkg::ADDR_POWER_CONTROL_REG
    |=> o_rdata[5:4] == {o_port2_rx_baud_select, o_port2_tx_baud_select})
    else $error("power control read wrong");
  chk_sclk_low_span: assert property ($fell(o_txd) && o_rxd_oe |-> s_clk_low)
    else $error("shift clock low span wrong");
  chk_shift_clk_high: assert property (o_rxd_oe && $past(o_rxd_oe) && $changed(o_rxd_out)
    |-> o_txd)
    else $error("data moved while clock low");
  chk_eight_pulses: assert property ($fell(o_rxd_oe) |-> cnt_q == 4'h8)
    else $error("shift pulse count wrong");
  chk_send_start: assert property (i_wr && i_addr == sp_pkg::ADDR_SERIAL_BUFFER && mode0_q
    && !o_rxd_oe |-> ##[1:26] $rose(o_rxd_oe))
    else $error("shift send did not start");
  chk_m0_rx_start: assert property (m0_wr && i_wdata[sp_pkg::SC_REN]
    && !i_wdata[sp_pkg::SC_RI] |-> ##[1:40] $fell(o_txd))
    else $error("shift receive did not start");
endmodule
bind sp_serial_port sp_serial_port_sva i_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rxd_out(o_rxd_out),
  .o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_port2_tx_baud_select(o_port2_tx_baud_select),
  .o_port2_rx_baud_select(o_port2_rx_baud_select)
);
`default_nettype wire

/* File: bench/tb_sp_serial_port.sv */
// testbench: register-level tests of the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_sp_serial_port;
  localparam int BIT = 64; // 32 x (65536 - 16'hfffe) clocks per bit
  logic       clk, rst_n, wr, rd, ext, rxo, oe, txd, p_rxd, s2t, s2r, pt;
  logic [2:0] addr;
  logic [7:0] wd, rdata, v;
  logic [9:0] fr;
  int         n_mismatch, cmp_count, i, n;
  wire logic  pin = oe ? rxo : p_rxd;
  sp_peer i_peer (.i_sys_clk(clk), .i_sclk(txd), .o_rxd(p_rxd));
  sp_serial_port i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_rxd(pin), .o_rxd_out(rxo), .o_rxd_oe(oe),
    .o_txd(txd), .i_t2_count_pin(1'b1), .i_t2_ext_pin(ext), .i_timer1_ovf(1'b0),
    .o_port2_tx_baud_select(s2t), .o_port2_rx_baud_select(s2r)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // bus and compare tasks
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(nm, e, rdata & m);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    ext = 1'b1;
    addr = 3'h0;
    wd = 8'h00;
    pt = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wrr(sp_pkg::ADDR_POWER_CONTROL_REG, 8'h30);
    rdc("power_control_reg", sp_pkg::ADDR_POWER_CONTROL_REG, 8'h30, 8'h30);
    cmp("p2sel", 8'h03, {6'h00, s2r, s2t});
    $display("test power_control_reg done");
    wrr(sp_pkg::ADDR_RLLO, 8'hfe);
    wrr(sp_pkg::ADDR_RLHI, 8'hff);
    // preset the counter too, or the first overflow is 64k steps away
    wrr(sp_pkg::ADDR_T2LO, 8'hfe);
    wrr(sp_pkg::ADDR_T2HI, 8'hff);
    wrr(sp_pkg::ADDR_TIMER2_CONTROL_REG, 8'h3c);
    wrr(sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h50);
    wrr(sp_pkg::ADDR_SERIAL_BUFFER, 8'h96);
    fr = {1'b1, 8'h96, 1'b0};
    i = 0;
    while (txd === 1'b1 && i < 4000) begin
      @(posedge clk);
      i++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      cmp("txbit", {7'h00, fr[k]}, {7'h00, txd});
      repeat (BIT) @(posedge clk);
    end
    rdc("ti", sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h02, 8'h02);
    $display("test async tx done");
    wrr(sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h50);
    i_peer.glitch(8);
    repeat (BIT) @(posedge clk);
    i_peer.send(8'h5a, BIT);
    repeat (BIT) @(posedge clk);
    rdc("rxbuf", sp_pkg::ADDR_SERIAL_BUFFER, 8'hff, 8'h5a);
    rdc("rxflag", sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h05, 8'h05);
    i_peer.send(8'h11, BIT);
    repeat (BIT) @(posedge clk);
    rdc("rxkeep", sp_pkg::ADDR_SERIAL_BUFFER, 8'hff, 8'h5a);
    $display("test async rx done");
    rdc("tf", sp_pkg::ADDR_TIMER2_CONTROL_REG, 8'h80, 8'h00);
    ext <= 1'b0;
    repeat (8) @(posedge clk);
    ext <= 1'b1;
    rdc("exf", sp_pkg::ADDR_TIMER2_CONTROL_REG, 8'h40, 8'h40);
    wrr(sp_pkg::ADDR_TIMER2_CONTROL_REG, 8'h38);
    rdc("t2hi", sp_pkg::ADDR_T2HI, 8'hff, 8'hff);
    $display("test timer done");
    wrr(sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h00);
    wrr(sp_pkg::ADDR_SERIAL_BUFFER, 8'ha5);
    v = 8'h00;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (oe === 1'b1 && txd === 1'b1 && pt === 1'b0) begin
        v = {rxo, v[7:1]};
        n++;
      end
      pt = txd;
    end
    cmp("m0tx", 8'ha5, v);
    cmp("m0n", 8'h08, n[7:0]);
    rdc("m0ti", sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h02, 8'h02);
    i_peer.arm(8'h3c);
    wrr(sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h10);
    repeat (160) @(posedge clk);
    rdc("m0rx", sp_pkg::ADDR_SERIAL_BUFFER, 8'hff, 8'h3c);
    rdc("m0ri", sp_pkg::ADDR_SERIAL_CONTROL_REG, 8'h01, 8'h01);
    $display("test shift mode done");
    complete_run();
  end
endmodule
`default_nettype wire
